// ### alarm_pkg.sv
package alarm_pkg;
  // Channel layout: 4 analog inputs, 3 temperature monitors
  localparam int N_IN   = 4;
  localparam int N_TMP  = 3;
  localparam int N_CH   = N_IN + N_TMP;
  localparam int DW     = 12;
  // Status bit layout: 0..3 inputs, 4..9 temp high/low pairs, 10 diode, 11 die
  localparam int N_ST   = 12;
  localparam int ST_TMP = 4;
  localparam int ST_DIO = 10;
  localparam int ST_DIE = 11;
  // Register offsets (word addresses on the plain port)
  localparam logic [4:0] A_STATUS  = 5'h00;
  localparam logic [4:0] A_CTRL    = 5'h01;
  localparam logic [4:0] A_CFG1    = 5'h02;
  localparam logic [4:0] A_SWRST   = 5'h03;
  localparam logic [4:0] A_MASK    = 5'h04;
  localparam logic [4:0] A_FLAGS   = 5'h05;
  localparam logic [4:0] A_HI0     = 5'h08;
  localparam logic [4:0] A_LO0     = 5'h10;
  localparam logic [4:0] A_HYS0    = 5'h18;
  // Field positions
  localparam int CTRL_EN_POS    = 12;
  localparam int CTRL_LDIS_POS  = 13;
  localparam int CFG1_INFC_POS  = 0;
  localparam int CFG1_TFC_POS   = 3;
  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CFG1_INFC_RST = 16'h0003;
  localparam logic [1:0]  TFC_RST    = 2'h2;
  localparam logic [2:0]  INFC_RST   = 3'h3;
  localparam logic [11:0] HI_RST     = 12'hFFF;
  localparam logic [11:0] LO_RST     = 12'h000;
  localparam logic [6:0]  HYS_RST    = 7'h08;
  localparam logic [15:0] SWRST_KEY  = 16'h6600;
  localparam logic [11:0] DIE_HYS    = 12'h008;
  localparam logic [8:0]  CNT_MAX    = 9'h100;
  // Software reset blocks the port for 30 us
  localparam int CLK_MHZ      = 40;
  localparam int SWRST_US     = 30;
  localparam int SWRST_CYC    = SWRST_US * CLK_MHZ;
endpackage

// ### alarm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Overview of operation
// - Alarm pin pulls low, else released
// - Unmasked enabled event activates alarm pin
// - Alarm output disabled: status sets, pin idle
// - Latched bit holds until status read, resolved or not
// - Status read clears bits; persisting reasserts
// - Hardware, software, power-on reset clear status
// - Latch disabled: bit follows condition directly
// - Clear only past hysteresis inside thresholds
// - Per-channel hysteresis, 7 or 5 bits
// - Die overtemperature hysteresis fixed eight degrees
// - Channel bits set only after N consecutive violations; diode and die bits set at once
// - Input N select 1..256, default 16
// - Temperature N select 1..8, default 4
// - Reset pin low holds register defaults
// - Software reset write restores defaults
// - Power-on reset equals hardware reset
// - Global flag ORs all status bits
// ----------------------------------------------------------------------------
module alarm_monitor
  import alarm_pkg::*;
#(
  parameter int SWRST_CYCLES = SWRST_CYC
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  input  wire logic          por_b_i,
  input  wire logic          spi_mode_i,
  input  wire logic [4:0]    addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [15:0]   rdata_o,
  output logic               busy_o,
  input  wire logic          conv_valid_i,
  input  wire logic [2:0]    conv_ch_i,
  input  wire logic [11:0]   conv_data_i,
  input  wire logic          diode_fault_i,
  input  wire logic [11:0]   die_temp_i,
  input  wire logic [11:0]   die_limit_i,
  output logic               alarm_oe_b_o,
  output logic               alarm_drv_o,
  output logic               irq_o,
  output logic               global_flag_o
);

  // ---------------------------------------------------------------------------
  // Reset combine
  // ---------------------------------------------------------------------------
  logic         rst_all_b;
  logic         swrst_r;
  logic [15:0]  ctrl_r;
  logic [15:0]  cfg1_r;
  logic [11:0]  hi_r  [N_CH];
  logic [11:0]  lo_r  [N_CH];
  logic [6:0]   hys_r [N_CH];
  logic [N_ST-1:0] status_r;
  logic [N_ST-1:0] cond_r;
  logic [N_ST-1:0] mask_r;
  logic [8:0]   cnt_r [N_CH];
  logic [31:0]  blk_r;
  logic         rd_ok;
  logic         wr_ok;

  assign rst_all_b = rst_b_i & por_b_i;
  assign rd_ok = rd_i & ~busy_o;
  assign wr_ok = wr_i & ~busy_o;

  function automatic logic [8:0] in_n(input logic [2:0] c);
    in_n = 9'h001 << ((c == 3'h0) ? 4'h0 : 4'(c) + 4'h1);
  endfunction

  function automatic logic [8:0] tmp_n(input logic [1:0] c);
    tmp_n = 9'h001 << c;
  endfunction

  // ---------------------------------------------------------------------------
  // Software reset
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= wr_ok && addr_i == A_SWRST && (!spi_mode_i || wdata_i == SWRST_KEY);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      blk_r  <= 32'h0000_0000;
      busy_o <= 1'b0;
    end else begin
      if (swrst_r) begin
        blk_r  <= 32'(SWRST_CYCLES);
        busy_o <= 1'b1;
      end else if (blk_r != 32'h0000_0000) begin
        blk_r  <= blk_r - 32'h0000_0001;
        busy_o <= (blk_r != 32'h0000_0001);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // defaults while reset low
  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      ctrl_r <= CTRL_RST;
      cfg1_r <= CFG1_INFC_RST | (16'(TFC_RST) << CFG1_TFC_POS);
      mask_r <= '0;
    end else if (swrst_r) begin
      ctrl_r <= CTRL_RST;
      cfg1_r <= CFG1_INFC_RST | (16'(TFC_RST) << CFG1_TFC_POS);
      mask_r <= '0;
    end else if (wr_ok) begin
      if (addr_i == A_CTRL) ctrl_r <= wdata_i;
      if (addr_i == A_CFG1) cfg1_r <= wdata_i;
      if (addr_i == A_MASK) mask_r <= wdata_i[N_ST-1:0];
    end
  end

  generate
    for (genvar g = 0; g < N_CH; g++) begin : g_thr
      always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
        if (!rst_all_b) begin
          hi_r[g]  <= HI_RST;
          lo_r[g]  <= LO_RST;
          hys_r[g] <= HYS_RST;
        end else if (swrst_r) begin
          hi_r[g]  <= HI_RST;
          lo_r[g]  <= LO_RST;
          hys_r[g] <= HYS_RST;
        end else if (wr_ok) begin
          if (addr_i == A_HI0 + 5'(g)) hi_r[g] <= wdata_i[11:0];
          if (addr_i == A_LO0 + 5'(g)) lo_r[g] <= wdata_i[11:0];
          if (addr_i == A_HYS0 + 5'(g)) begin
            hys_r[g] <= (g < N_IN) ? wdata_i[6:0] : {2'b00, wdata_i[4:0]};
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Per-channel filter and hysteresis
  // ---------------------------------------------------------------------------
  logic [N_CH-1:0] cv_hi;
  logic [N_CH-1:0] cv_lo;
  logic [N_CH-1:0] clr_hi;
  logic [N_CH-1:0] clr_lo;

  generate
    for (genvar g = 0; g < N_CH; g++) begin : g_chan
      logic [12:0] hi_cl;
      logic [12:0] lo_cl;
      logic [8:0]  n_sel;
      assign cv_hi[g] = conv_data_i > hi_r[g];
      assign cv_lo[g] = conv_data_i < lo_r[g];
      assign hi_cl = {1'b0, hi_r[g]} - {6'h00, hys_r[g]};
      assign lo_cl = {1'b0, lo_r[g]} + {6'h00, hys_r[g]};
      assign clr_hi[g] = !hi_cl[12] && {1'b0, conv_data_i} <= hi_cl;
      assign clr_lo[g] = {1'b0, conv_data_i} >= lo_cl;
      assign n_sel = (g < N_IN) ? in_n(cfg1_r[CFG1_INFC_POS +: 3])
                                : tmp_n(cfg1_r[CFG1_TFC_POS +: 2]);

      always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
        if (!rst_all_b) begin
          cnt_r[g] <= '0;
        end else if (swrst_r) begin
          cnt_r[g] <= '0;
        end else if (conv_valid_i && conv_ch_i == 3'(g)) begin
          if (!(cv_hi[g] || cv_lo[g])) cnt_r[g] <= '0;
          else if (cnt_r[g] < n_sel) cnt_r[g] <= cnt_r[g] + 9'h001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Condition and status bits
  // ---------------------------------------------------------------------------
  logic [N_ST-1:0] cond_nxt;
  logic            ldis;
  assign ldis = ctrl_r[CTRL_LDIS_POS];

  always_comb begin
    logic [8:0] n;
    logic       hit;
    cond_nxt = cond_r;
    n = 9'h000;
    hit = 1'b0;
    for (int c = 0; c < N_CH; c++) begin
      if (conv_valid_i && conv_ch_i == 3'(c)) begin
        n = (c < N_IN) ? in_n(cfg1_r[CFG1_INFC_POS +: 3])
                       : tmp_n(cfg1_r[CFG1_TFC_POS +: 2]);
        hit = (cv_hi[c] || cv_lo[c]) && (cnt_r[c] + 9'h001 >= n);
        if (c < N_IN) begin
          if (hit) cond_nxt[c] = 1'b1;
          else if (clr_hi[c] && clr_lo[c]) cond_nxt[c] = 1'b0;
        end else begin
          if (hit && cv_hi[c]) cond_nxt[ST_TMP + 2*(c-N_IN)] = 1'b1;
          else if (clr_hi[c]) cond_nxt[ST_TMP + 2*(c-N_IN)] = 1'b0;
          if (hit && cv_lo[c]) cond_nxt[ST_TMP + 2*(c-N_IN) + 1] = 1'b1;
          else if (clr_lo[c]) cond_nxt[ST_TMP + 2*(c-N_IN) + 1] = 1'b0;
        end
      end
    end
    cond_nxt[ST_DIO] = diode_fault_i;
    if (die_temp_i > die_limit_i) cond_nxt[ST_DIE] = 1'b1;
    else if ({1'b0, die_temp_i} + {1'b0, DIE_HYS} <= {1'b0, die_limit_i}) cond_nxt[ST_DIE] = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      cond_r <= '0;
    end else if (swrst_r) begin
      cond_r <= '0;
    end else begin
      cond_r <= cond_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      status_r <= '0;
    end else if (swrst_r) begin
      status_r <= '0;
    end else if (ldis) begin
      status_r <= cond_nxt;
    end else begin
      status_r <= ((rd_ok && addr_i == A_STATUS) ? '0 : status_r)
                | (cond_nxt & ~cond_r) | (cond_nxt & {N_ST{conv_valid_i}});
    end
  end

  // ---------------------------------------------------------------------------
  // Alarm outputs and read port
  // ---------------------------------------------------------------------------
  logic alarm_act;
  assign alarm_act = ctrl_r[CTRL_EN_POS] && |(status_r & ctrl_r[N_ST-1:0]);

  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      alarm_oe_b_o  <= 1'b1;
      alarm_drv_o   <= 1'b0;
      irq_o         <= 1'b0;
      global_flag_o <= 1'b0;
    end else begin
      alarm_oe_b_o  <= ~alarm_act;
      alarm_drv_o   <= 1'b0;
      irq_o         <= |(status_r & mask_r);
      global_flag_o <= |status_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      rdata_o <= 16'h0000;
    end else if (rd_ok) begin
      if (addr_i == A_STATUS) rdata_o <= 16'(status_r);
      else if (addr_i == A_CTRL) rdata_o <= ctrl_r;
      else if (addr_i == A_CFG1) rdata_o <= cfg1_r;
      else if (addr_i == A_MASK) rdata_o <= 16'(mask_r);
      else if (addr_i == A_FLAGS) rdata_o <= 16'(cond_r);
      else if (addr_i >= A_HI0 && addr_i < A_HI0 + 5'(N_CH)) rdata_o <= 16'(hi_r[3'(addr_i - A_HI0)]);
      else if (addr_i >= A_LO0 && addr_i < A_LO0 + 5'(N_CH)) rdata_o <= 16'(lo_r[3'(addr_i - A_LO0)]);
      else if (addr_i >= A_HYS0 && addr_i < A_HYS0 + 5'(N_CH)) rdata_o <= 16'(hys_r[3'(addr_i - A_HYS0)]);
      else rdata_o <= 16'h0000;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_od;
    @(posedge clk_sys_i) disable iff (!rst_all_b) !alarm_drv_o;
  endproperty
  a_od: assert property (p_od) else $error("alarm drives high");

  property p_en;
    @(posedge clk_sys_i) disable iff (!rst_all_b) alarm_act |=> !alarm_oe_b_o;
  endproperty
  a_en: assert property (p_en) else $error("alarm not driven");

  property p_mask;
    @(posedge clk_sys_i) disable iff (!rst_all_b) !ctrl_r[CTRL_EN_POS] |=> alarm_oe_b_o;
  endproperty
  a_mask: assert property (p_mask) else $error("alarm with enable off");

  property p_latch;
    @(posedge clk_sys_i) disable iff (!rst_all_b)
      (!ldis && !swrst_r && !(rd_ok && addr_i == A_STATUS))
      |=> ((status_r & ~$past(status_r) & ~$past(cond_nxt)) == '0)
          && ((status_r | ~$past(status_r)) == '1);
  endproperty
  a_latch: assert property (p_latch) else $error("latched bit lost");

  property p_rd;
    @(posedge clk_sys_i) disable iff (!rst_all_b)
      (!ldis && rd_ok && addr_i == A_STATUS && !conv_valid_i && cond_nxt == cond_r && !swrst_r) |=> status_r == '0;
  endproperty
  a_rd: assert property (p_rd) else $error("read did not clear");

  property p_sw;
    @(posedge clk_sys_i) disable iff (!rst_all_b) swrst_r |=> status_r == '0 && ctrl_r == CTRL_RST;
  endproperty
  a_sw: assert property (p_sw) else $error("software reset incomplete");

  property p_ldis;
    @(posedge clk_sys_i) disable iff (!rst_all_b) (ldis && !swrst_r) |=> status_r == cond_r;
  endproperty
  a_ldis: assert property (p_ldis) else $error("transparent mismatch");

  property p_gf;
    @(posedge clk_sys_i) disable iff (!rst_all_b) ##1 global_flag_o == |$past(status_r);
  endproperty
  a_gf: assert property (p_gf) else $error("global flag wrong");

  property p_sat;
    @(posedge clk_sys_i) disable iff (!rst_all_b) cnt_r[0] <= CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter overrun");

  property p_tsat;
    @(posedge clk_sys_i) disable iff (!rst_all_b) cnt_r[N_IN] <= tmp_n(2'h3);
  endproperty
  a_tsat: assert property (p_tsat) else $error("temperature counter overrun");

  property p_filt;
    @(posedge clk_sys_i) disable iff (!rst_all_b)
      (conv_valid_i && conv_ch_i == 3'h0 && !cond_r[0] && !swrst_r
       && cnt_r[0] + 9'h001 < in_n(cfg1_r[CFG1_INFC_POS +: 3])) |=> !cond_r[0];
  endproperty
  a_filt: assert property (p_filt) else $error("alarm set before N samples");

  property p_hys;
    @(posedge clk_sys_i) disable iff (!rst_all_b)
      (conv_valid_i && conv_ch_i == 3'h0 && cond_r[0] && !clr_hi[0] && !swrst_r)
      |=> cond_r[0];
  endproperty
  a_hys: assert property (p_hys) else $error("alarm cleared inside hysteresis");

  property p_busy;
    @(posedge clk_sys_i) disable iff (!rst_all_b) swrst_r |=> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("port not blocked");

  property p_refuse;
    @(posedge clk_sys_i) disable iff (!rst_all_b) (busy_o && wr_i) |=> $stable(ctrl_r);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken while blocked");

  c_alarm: cover property (@(posedge clk_sys_i) disable iff (!rst_all_b) !alarm_oe_b_o);
  c_rdclr: cover property (@(posedge clk_sys_i) disable iff (!rst_all_b)
    rd_ok && addr_i == A_STATUS && |status_r);
  c_swrst: cover property (@(posedge clk_sys_i) disable iff (!rst_all_b) swrst_r);
  c_refuse: cover property (@(posedge clk_sys_i) disable iff (!rst_all_b) busy_o && wr_i);

endmodule
`default_nettype wire

// ### alarm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the alarm line
// ----------------------------------------
module alarm_host (
  input  wire logic alarm_oe_b_i,
  input  wire logic alarm_drv_i,
  output logic      alarm_line_o
);
  assign alarm_line_o = alarm_oe_b_i ? 1'b1 : alarm_drv_i;
endmodule
`default_nettype wire

// ### test_alarm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_alarm_monitor;
  import alarm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        por_b_i = 1'b1;
  logic        spi_mode_i = 1'b0;
  logic [4:0]  addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        conv_valid_i = 1'b0;
  logic [2:0]  conv_ch_i = 3'h0;
  logic [11:0] conv_data_i = 12'h000;
  logic        diode_fault_i = 1'b0;
  logic [11:0] die_temp_i = 12'h000;
  logic [11:0] die_limit_i = 12'h100;
  logic [15:0] rdata_o;
  logic        busy_o;
  logic        alarm_oe_b_o;
  logic        alarm_drv_o;
  logic        irq_o;
  logic        global_flag_o;
  logic        alarm_line;
  int          fails = 0;
  int          check_count = 0;

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Short busy window keeps the run brief
  alarm_monitor #(.SWRST_CYCLES(8)) alarm_monitor_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
    .spi_mode_i(spi_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
    .conv_valid_i(conv_valid_i), .conv_ch_i(conv_ch_i),
    .conv_data_i(conv_data_i), .diode_fault_i(diode_fault_i),
    .die_temp_i(die_temp_i), .die_limit_i(die_limit_i),
    .alarm_oe_b_o(alarm_oe_b_o), .alarm_drv_o(alarm_drv_o),
    .irq_o(irq_o), .global_flag_o(global_flag_o)
  );

  alarm_host alarm_host_inst (
    .alarm_oe_b_i(alarm_oe_b_o),
    .alarm_drv_i(alarm_drv_o),
    .alarm_line_o(alarm_line)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic cv(input logic [2:0] c, input logic [11:0] d, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      conv_valid_i <= 1'b1;
      conv_ch_i <= c;
      conv_data_i <= d;
      @(posedge clk_sys_i);
      conv_valid_i <= 1'b0;
    end
    repeat (3) @(posedge clk_sys_i);
  endtask

  // One short run broken before N, then exactly N
  task automatic filt(input logic [2:0] c, input int b, input int n);
    cv(c, 12'hF00, n - 1);
    cv(c, 12'h100, 1);
    cv(c, 12'hF00, n - 1);
    rd(A_STATUS, 16'h0000);
    cv(c, 12'hF00, 1);
    rd(A_STATUS, 16'(1 << b));
    cv(c, 12'h100, 1);
    rd(A_STATUS, 16'h0000);
  endtask

  task automatic wait_idle();
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 200 && busy_o !== 1'b0; i++) @(posedge clk_sys_i);
  endtask

  task automatic done(input string name);
    $display("test %s done: checks=%0d fails=%0d", name, check_count, fails);
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 80000);
    fails++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(A_CTRL, 16'h0000);
    rd(A_CFG1, 16'h0013);
    rd(A_HI0, 16'h0FFF);
    rd(A_LO0, 16'h0000);
    rd(A_HYS0, 16'h0008);
    rd(5'h07, 16'h0000);
    wr(A_HYS0, 16'hFFFF);
    rd(A_HYS0, 16'h007F);
    wr(A_HYS0 + 5'h04, 16'hFFFF);
    rd(A_HYS0 + 5'h04, 16'h001F);
    wr(A_HYS0, 16'h0008);
    wr(A_HI0, 16'h0800);
    wr(A_HI0 + 5'h04, 16'h0800);
    done("defaults");
    for (int k = 0; k < 8; k++) begin
      wr(A_CFG1, 16'(k) | 16'h0010);
      filt(3'h0, 0, (k == 0) ? 1 : (2 << k));
    end
    for (int k = 0; k < 4; k++) begin
      wr(A_CFG1, 16'(k << 3));
      filt(3'h4, ST_TMP, 1 << k);
    end
    done("filter");
    wr(A_CTRL, 16'h0FFF);
    cv(3'h0, 12'hF00, 1);
    chk(global_flag_o, 16'h0001);
    chk(alarm_line, 16'h0001);
    wr(A_CTRL, 16'h1FFF);
    repeat (3) @(posedge clk_sys_i);
    chk(alarm_line, 16'h0000);
    wr(A_CTRL, 16'h1FFE);
    repeat (3) @(posedge clk_sys_i);
    chk(alarm_line, 16'h0001);
    wr(A_MASK, 16'h0001);
    repeat (3) @(posedge clk_sys_i);
    chk(irq_o, 16'h0001);
    wr(A_MASK, 16'h0000);
    repeat (3) @(posedge clk_sys_i);
    chk(irq_o, 16'h0000);
    done("alarm pin");
    rd(A_STATUS, 16'h0001);
    rd(A_STATUS, 16'h0000);
    cv(3'h0, 12'hF00, 1);
    rd(A_STATUS, 16'h0001);
    cv(3'h0, 12'h7FC, 1);
    rd(A_FLAGS, 16'h0001);
    cv(3'h0, 12'h7F8, 1);
    rd(A_FLAGS, 16'h0000);
    rd(A_STATUS, 16'h0001);
    rd(A_STATUS, 16'h0000);
    wr(A_CTRL, 16'h3FFF);
    cv(3'h0, 12'hF00, 1);
    chk(global_flag_o, 16'h0001);
    cv(3'h0, 12'h7F8, 1);
    chk(global_flag_o, 16'h0000);
    done("latch");
    @(posedge clk_sys_i);
    die_temp_i <= 12'h101;
    diode_fault_i <= 1'b1;
    cv(3'h0, 12'h100, 1);
    rd(A_FLAGS, 16'h0C00);
    die_temp_i <= 12'h0F9;
    diode_fault_i <= 1'b0;
    cv(3'h0, 12'h100, 1);
    rd(A_FLAGS, 16'h0800);
    die_temp_i <= 12'h0F8;
    cv(3'h0, 12'h100, 1);
    rd(A_FLAGS, 16'h0000);
    wr(A_CFG1, 16'h0000);
    wr(A_LO0 + 5'h04, 16'h0200);
    cv(3'h4, 12'h100, 1);
    rd(A_FLAGS, 16'h0020);
    cv(3'h4, 12'h210, 1);
    rd(A_FLAGS, 16'h0020);
    cv(3'h4, 12'h21F, 1);
    rd(A_FLAGS, 16'h0000);
    done("die");
    wr(A_CTRL, 16'h1FFF);
    cv(3'h0, 12'hF00, 1);
    spi_mode_i <= 1'b1;
    wr(A_SWRST, 16'h1234);
    wait_idle();
    rd(A_CTRL, 16'h1FFF);
    wr(A_SWRST, 16'h6600);
    repeat (2) @(posedge clk_sys_i);
    chk(busy_o, 16'h0001);
    wr(A_CTRL, 16'h1FFF);
    wait_idle();
    rd(A_CTRL, 16'h0000);
    rd(A_STATUS, 16'h0000);
    rd(A_HI0, 16'h0FFF);
    spi_mode_i <= 1'b0;
    wr(A_CTRL, 16'h1FFF);
    wr(A_SWRST, 16'h0001);
    wait_idle();
    rd(A_CTRL, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(A_CTRL, 16'h1FFF);
      wr(A_CFG1, 16'h0000);
      cv(3'h0, 12'hFFF, 1);
      wr(A_HI0, 16'h0100);
      cv(3'h0, 12'h200, 1);
      rst_b_i <= (k == 1);
      por_b_i <= (k == 0);
      repeat (2) @(posedge clk_sys_i);
      chk(alarm_oe_b_o, 16'h0001);
      rst_b_i <= 1'b1;
      por_b_i <= 1'b1;
      rd(A_CTRL, 16'h0000);
      rd(A_STATUS, 16'h0000);
      rd(A_HI0, 16'h0FFF);
    end
    done("reset");
    print_verdict();
  end
endmodule
`default_nettype wire
